/* dv/pmc_asserts.sv */
// pmc_asserts.sv: port checks for the power mode controller
// assumes it is bound to the controller; one clock, synchronous reset
`timescale 1ns/1ps
`include "pmc_defines.vh"
module pmc_asserts #(
  parameter NUM_PERIPH = 8
) (
  input wire clk,
  input wire rst,
  input wire clkEn,
  input wire anyIrq,
  input wire [`PMC_WAKE_WIDTH-1:0] wakeEvents,
  input wire resetPinEvent,
  input wire powerOnEvent,
  input wire coreClkEn,
  input wire [NUM_PERIPH-1:0] periphClkEn,
  input wire timerLfClkEn,
  input wire internalOsc24mEn,
  input wire internalOsc48mEn,
  input wire regLowBias,
  input wire reg18En,
  input wire pinHold,
  input wire [`PMC_CLKDIV_W-1:0] sysClkDiv,
  input wire [`PMC_MODE_W-1:0] modeOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // suspend and snooze share gating; stop and shutdown share the no-exit rule
  wire lowPower = (modeOut == `PMC_MODE_SUSPEND) || (modeOut == `PMC_MODE_SNOOZE);
  wire deep = (modeOut == `PMC_MODE_STOP) || (modeOut == `PMC_MODE_SHUTDOWN);
  // a reset is honoured unless the block sits in shutdown with neither pin nor power-on cause
  wire rstHonoured = resetPinEvent || powerOnEvent || (modeOut != `PMC_MODE_SHUTDOWN);
  // wake seen, then back in normal within the registered latency
  sequence wakeSeen; clkEn && lowPower && (|wakeEvents); endsequence
  sequence backNormal; ##[1:2] (modeOut == `PMC_MODE_NORMAL); endsequence
  chk_normal_run: assert property (
    modeOut == `PMC_MODE_NORMAL |-> coreClkEn && internalOsc24mEn) else $error("normal mode not running");
  chk_idle_halt: assert property (
    modeOut == `PMC_MODE_IDLE |-> !coreClkEn && internalOsc24mEn) else $error("idle core gate wrong");
  chk_idle_exit: assert property (
    clkEn && modeOut == `PMC_MODE_IDLE && anyIrq |-> backNormal) else $error("idle not left on irq");
  chk_lp_gating: assert property (
    lowPower |-> !coreClkEn && periphClkEn == 0 && !internalOsc24mEn && !internalOsc48mEn && timerLfClkEn)
    else $error("clock left running in low power");
  chk_lp_bias: assert property (
    lowPower |-> regLowBias == (modeOut == `PMC_MODE_SNOOZE)) else $error("regulator bias wrong");
  chk_wake_exit: assert property (wakeSeen |-> backNormal) else $error("wake ignored");
  chk_stop_power: assert property (
    modeOut == `PMC_MODE_STOP |-> reg18En && pinHold) else $error("stop power wrong");
  chk_shut_power: assert property (
    modeOut == `PMC_MODE_SHUTDOWN |-> !reg18En && pinHold) else $error("shutdown power wrong");
  chk_deep_hold: assert property (deep |=> $stable(modeOut)) else $error("deep mode left");
  chk_reset_div: assert property (
    $fell(rst) && $past(rstHonoured) |-> sysClkDiv == `PMC_CLKDIV_RESET && modeOut == `PMC_MODE_NORMAL)
    else $error("reset clock wrong");
  chk_shut_keep: assert property (
    disable iff (1'b0) rst && !rstHonoured |=> modeOut == `PMC_MODE_SHUTDOWN)
    else $error("shutdown left without pin or power-on reset");
endmodule

/* dv/pmc_tb.sv */
// pmc_tb.sv: apb-driven test of the power mode controller
// assumes controller, defines header and checker are compiled alongside
`timescale 1ns/1ps
`include "pmc_defines.vh"
module tb;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, anyIrq = 0, err;
  logic clkEn = 1, resetPinEvent = 0, powerOnEvent = 1; // power-on cause stands through the first reset
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdata;
  logic pready, pslverr, coreClkEn, lfClk, osc24, osc48, lowBias, reg18En, reg5En, pinHold, irq;
  logic [5:0] wakeEvents = '0;
  logic [7:0] periphClkEn;
  logic [2:0] sysClkDiv, modeOut;
  int n_fail = 0, n_compared = 0, cyc = 0;
  always #2.5 clk = ~clk;
  pmc_power_mode_controller #(.NUM_PERIPH(8)) i_pmc_power_mode_controller (
    .clk(clk), .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .anyIrq(anyIrq), .wakeEvents(wakeEvents), .resetPinEvent(resetPinEvent), .powerOnEvent(powerOnEvent),
    .coreClkEn(coreClkEn), .periphClkEn(periphClkEn), .timerLfClkEn(lfClk), .internalOsc24mEn(osc24),
    .internalOsc48mEn(osc48), .regLowBias(lowBias), .reg18En(reg18En), .reg5En(reg5En),
    .pinHold(pinHold), .sysClkDiv(sysClkDiv), .modeOut(modeOut), .irq(irq));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits on pready, the global timeout cuts a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, '0);
    check(rdata, exp);
  endtask
  // mode outputs are registered one edge after the request is taken
  task settle;
    repeat (3) @(posedge clk);
  endtask
  task doReset;
    rst <= 1;
    settle;
    rst <= 0;
    @(posedge clk);
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    powerOnEvent <= 0;
    @(posedge clk);
    check(sysClkDiv, `PMC_CLKDIV_RESET);
    check({coreClkEn, periphClkEn}, {1'b1, `PMC_PERIPH_RESET});
    rd(12'h01C, '0);
    check(err, 1'b1);
    $display("test reset done");
    wr(`PMC_ADDR_IRQMASK, 32'h2);
    wr(`PMC_ADDR_PCTL0, 32'h1);
    settle;
    check({modeOut, coreClkEn}, {`PMC_MODE_IDLE, 1'b0});
    // with the enable low an interrupt must not move the frozen state
    clkEn <= 0;
    anyIrq <= 1;
    settle;
    check(modeOut, `PMC_MODE_IDLE);
    clkEn <= 1;
    @(posedge clk);
    anyIrq <= 0;
    settle;
    check({modeOut, irq}, {`PMC_MODE_NORMAL, 1'b0});
    rd(`PMC_ADDR_PCTL0, '0);
    wr(`PMC_ADDR_IRQMASK, 32'h3);
    settle;
    check(irq, 1'b1);
    wr(`PMC_ADDR_IRQSTAT, 32'h1);
    settle;
    check(irq, 1'b0);
    $display("test idle done");
    for (int k = 0; k < 6; k++) begin
      // the system clock is still on the 24 MHz oscillator from reset, as suspend and snooze need
      check(sysClkDiv, `PMC_CLKDIV_RESET);
      wr(`PMC_ADDR_PCTL1, 32'h1 << (k % 2));
      settle;
      check(modeOut, `PMC_MODE_SUSPEND + k % 2);
      check({lowBias, lfClk, osc24, osc48}, {k % 2 == 1, 3'b100});
      wakeEvents <= 6'h1 << k;
      @(posedge clk);
      wakeEvents <= '0;
      settle;
      check({modeOut, irq}, {`PMC_MODE_NORMAL, 1'b1});
      rd(`PMC_ADDR_PCTL1, '0);
      rd(`PMC_ADDR_IRQSTAT, 32'h2);
      wr(`PMC_ADDR_IRQSTAT, 32'h2);
    end
    $display("test wake done");
    wr(`PMC_ADDR_PERIPHEN, 32'h0F);
    settle;
    check(periphClkEn, 8'h0F);
    wr(`PMC_ADDR_REGCTL, 32'h2);
    wr(`PMC_ADDR_PCTL0, 32'h2);
    settle;
    check({modeOut, reg18En, pinHold, reg5En}, {`PMC_MODE_STOP, 3'h7});
    anyIrq <= 1;
    wakeEvents <= 6'h3F;
    settle;
    anyIrq <= 0;
    wakeEvents <= '0;
    check(modeOut, `PMC_MODE_STOP);
    doReset;
    check(modeOut, `PMC_MODE_NORMAL);
    wr(`PMC_ADDR_REGCTL, 32'h3);
    wr(`PMC_ADDR_PCTL0, 32'h2);
    settle;
    check({modeOut, reg18En, pinHold, reg5En}, {`PMC_MODE_SHUTDOWN, 3'h3});
    // a reset with neither pin nor power-on cause must leave shutdown alone
    doReset;
    check(modeOut, `PMC_MODE_SHUTDOWN);
    resetPinEvent <= 1;
    doReset;
    resetPinEvent <= 0;
    check(modeOut, `PMC_MODE_NORMAL);
    $display("test deep modes done");
    test_done;
  end
endmodule
bind pmc_power_mode_controller pmc_asserts #(.NUM_PERIPH(NUM_PERIPH)) i_pmc_asserts (
  .clk, .rst, .clkEn, .anyIrq, .wakeEvents, .resetPinEvent, .powerOnEvent, .coreClkEn, .periphClkEn,
  .timerLfClkEn, .internalOsc24mEn,
  .internalOsc48mEn, .regLowBias, .reg18En, .pinHold, .sysClkDiv, .modeOut);

/* verilog/pmc_defines.vh */
// pmc_defines.vh: register offsets, field positions, reset values and codes for the power mode controller
// assumes it is included by the controller, its checker and its bench; definitions only
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH
// byte addresses of the apb registers (one aligned word each)
`define PMC_ADDR_PCTL0 12'h000
`define PMC_ADDR_PCTL1 12'h004
`define PMC_ADDR_REGCTL 12'h008
`define PMC_ADDR_STATUS 12'h00C
`define PMC_ADDR_IRQSTAT 12'h010
`define PMC_ADDR_IRQMASK 12'h014
`define PMC_ADDR_PERIPHEN 12'h018
// power control zero fields
`define PMC_BIT_IDLE 0
`define PMC_BIT_STOP 1
// power control one fields
`define PMC_BIT_SUSPEND 0
`define PMC_BIT_SNOOZE 1
// regulator control fields
`define PMC_BIT_STOPCFG 0
`define PMC_BIT_REG5EN 1
// interrupt status fields: one for idle exit, one shared by suspend and snooze exit
`define PMC_IRQ_IDLE_EXIT 0
`define PMC_IRQ_LP_EXIT 1
`define PMC_IRQ_WIDTH 2
// wake source positions
`define PMC_WAKE_WIDTH 6
// mode codes
`define PMC_MODE_W 3
`define PMC_MODE_NORMAL 3'h0
`define PMC_MODE_IDLE 3'h1
`define PMC_MODE_SUSPEND 3'h2
`define PMC_MODE_SNOOZE 3'h3
`define PMC_MODE_STOP 3'h4
`define PMC_MODE_SHUTDOWN 3'h5
// clock divider code after reset: divide by 8
`define PMC_CLKDIV_W 3
`define PMC_CLKDIV_RESET 3'h3
// reset value of the peripheral clock enables: all on
`define PMC_PERIPH_RESET 8'hFF
`endif

/* verilog/pmc_power_mode_controller.v */
// pmc_power_mode_controller.v: power mode sequencer with apb registers and a mode-exit interrupt
// assumes one clock, synchronous active-high reset from any reset source, inputs synchronous to clk
// assumes software has put the system clock on the 24 MHz oscillator before suspend or snooze
// Operation
// - normal mode: core and enabled peripherals clocked
// - idle halts core; any interrupt resumes
// - suspend: clocks halted, oscillators off, normal bias
// - timers three/four keep low-frequency clock
// - six wake events end suspend or snooze
// - snooze: like suspend but low bias
// - stop: 1.8 V kept, pins held, reset exits
// - shutdown: 1.8 V off, pin/power-on reset exits
// - 5V regulator stays on if enabled
// - after reset clock is 24 MHz over 8
// - unused digital peripheral clocks gated off
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "pmc_defines.vh"
module pmc_power_mode_controller #(
  parameter NUM_PERIPH = 8
) (
  // clock, reset and the freeze enable
  input wire clk,
  input wire rst,
  input wire clkEn,
  // apb register port, zero wait states
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // wake and reset causes from the rest of the chip
  input wire anyIrq,
  input wire [`PMC_WAKE_WIDTH-1:0] wakeEvents,
  input wire resetPinEvent,
  input wire powerOnEvent,
  // clock gates, oscillator and regulator controls
  output reg coreClkEn,
  output reg [NUM_PERIPH-1:0] periphClkEn,
  output reg timerLfClkEn,
  output reg internalOsc24mEn,
  output reg internalOsc48mEn,
  output reg regLowBias,
  output reg reg18En,
  output reg reg5En,
  output reg pinHold,
  // system clock divider code, current mode and the interrupt line
  output reg [`PMC_CLKDIV_W-1:0] sysClkDiv,
  output reg [`PMC_MODE_W-1:0] modeOut,
  output reg irq
);
  // software-visible state
  // request bits, one per low-power mode except shutdown, which the stop bit requests
  reg idleReq_reg;
  reg stopReq_reg;
  reg suspendReq_reg;
  reg snoozeReq_reg;
  reg stopCfg_reg;
  reg reg5Enable_reg;
  reg [NUM_PERIPH-1:0] periphEn_reg; // software's enable per peripheral
  reg [`PMC_IRQ_WIDTH-1:0] irqStat_reg;
  reg [`PMC_IRQ_WIDTH-1:0] irqMask_reg;
  // mode state and its next value
  reg [`PMC_MODE_W-1:0] mode_reg;
  reg [`PMC_MODE_W-1:0] mode_next;
  // bus decode
  wire wrAccess;
  wire rdAccess;
  wire addrHit;
  wire anyWake;
  reg [31:0] rdData;
  assign wrAccess = psel & penable & pwrite;
  assign rdAccess = psel & penable & ~pwrite;
  assign addrHit = (paddr == `PMC_ADDR_PCTL0) | (paddr == `PMC_ADDR_PCTL1) |
                   (paddr == `PMC_ADDR_REGCTL) | (paddr == `PMC_ADDR_STATUS) |
                   (paddr == `PMC_ADDR_IRQSTAT) | (paddr == `PMC_ADDR_IRQMASK) |
                   (paddr == `PMC_ADDR_PERIPHEN);
  // the six wake lines are levels; any one of them ends suspend or snooze
  assign anyWake = |wakeEvents;
  // shutdown ignores reset causes other than the pin and power-on, since only those reach a powered-down core
  wire shutHold;
  wire rstTaken;
  assign shutHold = (mode_reg == `PMC_MODE_SHUTDOWN) & ~resetPinEvent & ~powerOnEvent;
  assign rstTaken = rst & ~shutHold;

  // next-mode logic; a request is acted on only from normal mode
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      `PMC_MODE_NORMAL: begin
        if (stopReq_reg) begin
          // stop config bit picks stop or shutdown
          mode_next = stopCfg_reg ? `PMC_MODE_SHUTDOWN : `PMC_MODE_STOP;
        end else if (snoozeReq_reg) begin
          mode_next = `PMC_MODE_SNOOZE;
        end else if (suspendReq_reg) begin
          mode_next = `PMC_MODE_SUSPEND;
        end else if (idleReq_reg) begin
          mode_next = `PMC_MODE_IDLE;
        end
      end
      `PMC_MODE_IDLE: begin
        // any interrupt request ends idle, masked or not
        if (anyIrq) begin
          mode_next = `PMC_MODE_NORMAL;
        end
      end
      `PMC_MODE_SUSPEND, `PMC_MODE_SNOOZE: begin
        // the cause is not recorded, only that a wake happened
        if (anyWake) begin
          mode_next = `PMC_MODE_NORMAL;
        end
      end
      // stop and shutdown leave only through a taken reset, handled in the reset branches
      `PMC_MODE_STOP, `PMC_MODE_SHUTDOWN: begin
        mode_next = mode_reg;
      end
      // an illegal code falls back to normal rather than locking up
      default: begin
        mode_next = `PMC_MODE_NORMAL;
      end
    endcase
  end

  // exits seen this cycle
  // they set the sticky status bits and clear the request bits
  wire idleExit;
  wire lpExit;
  assign idleExit = (mode_reg == `PMC_MODE_IDLE) & (mode_next == `PMC_MODE_NORMAL);
  assign lpExit = ((mode_reg == `PMC_MODE_SUSPEND) | (mode_reg == `PMC_MODE_SNOOZE)) &
                  (mode_next == `PMC_MODE_NORMAL);

  // read mux
  // unmapped addresses and unused bits read as zero
  always @* begin
    rdData = 32'h00000000;
    case (paddr)
      `PMC_ADDR_PCTL0: begin
        rdData[`PMC_BIT_IDLE] = idleReq_reg;
        rdData[`PMC_BIT_STOP] = stopReq_reg;
      end
      `PMC_ADDR_PCTL1: begin
        rdData[`PMC_BIT_SUSPEND] = suspendReq_reg;
        rdData[`PMC_BIT_SNOOZE] = snoozeReq_reg;
      end
      `PMC_ADDR_REGCTL: begin
        rdData[`PMC_BIT_STOPCFG] = stopCfg_reg;
        rdData[`PMC_BIT_REG5EN] = reg5Enable_reg;
      end
      `PMC_ADDR_STATUS: rdData[`PMC_MODE_W-1:0] = mode_reg;
      `PMC_ADDR_IRQSTAT: rdData[`PMC_IRQ_WIDTH-1:0] = irqStat_reg;
      `PMC_ADDR_IRQMASK: rdData[`PMC_IRQ_WIDTH-1:0] = irqMask_reg;
      `PMC_ADDR_PERIPHEN: rdData[NUM_PERIPH-1:0] = periphEn_reg;
      default: rdData = 32'h00000000;
    endcase
  end

  // apb slave: zero wait states; pready pulses in the access phase
  // read data is latched in the setup cycle so it stands through the access edge
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clkEn) begin
      pready <= psel & ~penable; // answer at the first access-phase edge
      pslverr <= psel & ~penable & ~addrHit; // unmapped address reports an error
      if (psel & ~penable & ~pwrite) begin
        prdata <= rdData;
      end
    end
  end

  // registers and mode state; writes take effect on the edge that completes the access
  // request bits hold until a mode exit or a reset clears them or software rewrites them
  wire wrDone;
  assign wrDone = wrAccess & pready;
  always @(posedge clk) begin
    if (rstTaken) begin
      // any reset source ends stop; only pin or power-on ends shutdown
      idleReq_reg <= 1'b0;
      stopReq_reg <= 1'b0;
      suspendReq_reg <= 1'b0;
      snoozeReq_reg <= 1'b0;
      stopCfg_reg <= 1'b0;
      reg5Enable_reg <= 1'b0;
      periphEn_reg <= `PMC_PERIPH_RESET;
      irqStat_reg <= {`PMC_IRQ_WIDTH{1'b0}};
      irqMask_reg <= {`PMC_IRQ_WIDTH{1'b0}};
      mode_reg <= `PMC_MODE_NORMAL;
    end else if (clkEn) begin
      mode_reg <= mode_next;
      if (wrDone & (paddr == `PMC_ADDR_PCTL0)) begin
        idleReq_reg <= pwdata[`PMC_BIT_IDLE];
        stopReq_reg <= pwdata[`PMC_BIT_STOP];
      end
      if (wrDone & (paddr == `PMC_ADDR_PCTL1)) begin
        suspendReq_reg <= pwdata[`PMC_BIT_SUSPEND];
        snoozeReq_reg <= pwdata[`PMC_BIT_SNOOZE];
      end
      if (wrDone & (paddr == `PMC_ADDR_REGCTL)) begin
        stopCfg_reg <= pwdata[`PMC_BIT_STOPCFG];
        reg5Enable_reg <= pwdata[`PMC_BIT_REG5EN];
      end
      if (wrDone & (paddr == `PMC_ADDR_IRQMASK)) begin
        irqMask_reg <= pwdata[`PMC_IRQ_WIDTH-1:0];
      end
      if (wrDone & (paddr == `PMC_ADDR_PERIPHEN)) begin
        periphEn_reg <= pwdata[NUM_PERIPH-1:0];
      end
      // a wake clears the request so execution goes on in normal mode
      if (idleExit) begin
        idleReq_reg <= 1'b0;
      end
      if (lpExit) begin
        suspendReq_reg <= 1'b0;
        snoozeReq_reg <= 1'b0;
      end
      // write-one-to-clear, but a new exit event wins over the clear
      if (wrDone & (paddr == `PMC_ADDR_IRQSTAT)) begin
        irqStat_reg <= (irqStat_reg & ~pwdata[`PMC_IRQ_WIDTH-1:0]) |
                       {lpExit, idleExit};
      end else begin
        irqStat_reg <= irqStat_reg | {lpExit, idleExit};
      end
    end
  end

  // outputs decoded from the next mode so every output is a flip-flop
  // decoding mode_next keeps the gates in step with modeOut, at the cost of a longer path
  always @(posedge clk) begin
    if (rstTaken) begin
      // reset values: everything clocked, system clock at its slow start-up rate
      coreClkEn <= 1'b1;
      periphClkEn <= `PMC_PERIPH_RESET;
      timerLfClkEn <= 1'b1;
      internalOsc24mEn <= 1'b1;
      internalOsc48mEn <= 1'b1;
      regLowBias <= 1'b0;
      reg18En <= 1'b1;
      reg5En <= 1'b0;
      pinHold <= 1'b0;
      sysClkDiv <= `PMC_CLKDIV_RESET; // 24 MHz oscillator over 8
      modeOut <= `PMC_MODE_NORMAL;
      irq <= 1'b0;
    end else if (clkEn) begin
      modeOut <= mode_next;
      irq <= |(irqStat_reg & irqMask_reg);
      reg5En <= reg5Enable_reg; // unaffected by stop and shutdown
      sysClkDiv <= `PMC_CLKDIV_RESET;
      // timers three and four keep counting through every mode, so this gate never closes
      timerLfClkEn <= 1'b1; // low-frequency timer clock never gated
      case (mode_next)
        `PMC_MODE_NORMAL: begin
          // everything clocked; unused peripherals gated
          coreClkEn <= 1'b1;
          periphClkEn <= periphEn_reg;
          internalOsc24mEn <= 1'b1;
          internalOsc48mEn <= 1'b1;
          regLowBias <= 1'b0;
          reg18En <= 1'b1;
          pinHold <= 1'b0;
        end
        `PMC_MODE_IDLE: begin
          // core stopped, peripherals still clocked so they can raise interrupts
          coreClkEn <= 1'b0;
          periphClkEn <= periphEn_reg;
          internalOsc24mEn <= 1'b1;
          internalOsc48mEn <= 1'b1;
          regLowBias <= 1'b0;
          reg18En <= 1'b1;
          pinHold <= 1'b0;
        end
        `PMC_MODE_SUSPEND, `PMC_MODE_SNOOZE: begin
          // clocks and oscillators off; bias per mode
          coreClkEn <= 1'b0;
          periphClkEn <= {NUM_PERIPH{1'b0}};
          internalOsc24mEn <= 1'b0;
          internalOsc48mEn <= 1'b0;
          regLowBias <= (mode_next == `PMC_MODE_SNOOZE);
          reg18En <= 1'b1;
          pinHold <= 1'b0;
        end
        default: begin
          // stop keeps 1.8 V, shutdown drops it; pins held
          coreClkEn <= 1'b0;
          periphClkEn <= {NUM_PERIPH{1'b0}};
          internalOsc24mEn <= 1'b0;
          internalOsc48mEn <= 1'b0;
          regLowBias <= 1'b1;
          reg18En <= (mode_next == `PMC_MODE_STOP);
          pinHold <= 1'b1;
        end
      endcase
    end
  end
endmodule
